// *** src/tcteb_pkg.sv ***
// Purpose: shared constants of the 8-bit timer/event counter with buzzer
// Assumes: 8-bit register port, one clock
// Notes:   offsets are byte addresses on the register port
package tcteb_pkg;

	// register offsets
	localparam logic [7:0] TCTEB_OFS_RELOAD = 8'hcd;
	localparam logic [7:0] TCTEB_OFS_MODE   = 8'hda;
	localparam logic [7:0] TCTEB_OFS_COUNT  = 8'hdb;
	localparam logic [7:0] TCTEB_OFS_STATUS = 8'hc8;

	// timer_mode_control field positions
	localparam int TCTEB_BIT_PWM_EN   = 0;
	localparam int TCTEB_BIT_TOGGLE   = 1;
	localparam int TCTEB_BIT_RELOAD   = 2;
	localparam int TCTEB_BIT_CLK_SRC  = 3;
	localparam int TCTEB_BIT_RATE_LO  = 4;
	localparam int TCTEB_BIT_RATE_HI  = 6;
	localparam int TCTEB_BIT_ENABLE   = 7;

	// status register field positions
	localparam int TCTEB_BIT_FLAG     = 0;
	localparam int TCTEB_BIT_IEN      = 1;

	// reset values
	localparam logic [7:0] TCTEB_RST_MODE   = 8'h00;
	localparam logic [7:0] TCTEB_RST_COUNT  = 8'h00;
	localparam logic [7:0] TCTEB_RST_RELOAD = 8'h00;

	// overflow boundary masks: 256, 64, 32 and 16 counts
	localparam logic [7:0] TCTEB_MASK_256 = 8'hff;
	localparam logic [7:0] TCTEB_MASK_64  = 8'h3f;
	localparam logic [7:0] TCTEB_MASK_32  = 8'h1f;
	localparam logic [7:0] TCTEB_MASK_16  = 8'h0f;

	// prescaler: code 0 divides by 256, each step halves the divisor
	localparam logic [7:0] TCTEB_PRE_MASK_MAX = 8'hff;
	localparam logic [7:0] TCTEB_PRE_RST      = 8'h00;

endpackage

// *** src/tcteb_prescaler.sv ***
// Purpose: instruction clock prescaler, divide by 256 down to 2
// Assumes: run low clears the divider so a new start is aligned
// Notes:   tick is one mclk cycle wide and comes from a flip-flop
`timescale 1ns/1ps
`default_nettype none
module tcteb_prescaler
	import tcteb_pkg::*;
(
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       sys_rst,
	// control
	input  wire logic       run,
	input  wire logic [2:0] rate,
	// divided clock enable
	output var  logic       tick
);

	typedef struct packed {
		logic [7:0] div;
		logic       tick;
	} tcteb_pre_t;

	tcteb_pre_t state;
	tcteb_pre_t next_state;
	logic [7:0] mask;

	assign mask = TCTEB_PRE_MASK_MAX >> rate;

	always_comb begin
		next_state = state;
		if (run) begin
			next_state.div  = state.div + 8'h01;
			next_state.tick = ((state.div & mask) == mask);
		end else begin
			next_state.div  = TCTEB_PRE_RST;
			next_state.tick = 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign tick = state.tick;

endmodule
`default_nettype wire

// *** src/tcteb_timer.sv ***
// Purpose: 8-bit up timer/event counter with reload, buzzer and PWM
// Assumes: pins and register port synchronous to mclk
// Notes:   counter write wins over a count step in the same cycle
//
// Overview of operation
// - pwm enable drives pin with PWM waveform
// - toggle enable routes buzzer to pin when PWM is off
// - reload bit enables reload outside PWM
// - clock source selects prescaler or pin
// - prescaler codes divide 256 down to 2
// - enable bit starts or stops counting
// - event mode blocks pin interrupt flag
// - overflow sets sticky flag until cleared
// - reload loads counter at overflow automatically
// - PWM bits choose 256, 64, 32, 16 boundary with the prescaler clock; with the pin clock the boundary stays 256
// - reduced modes use only low counter bits
// - reload write waits in holding buffer
// - event mode counts falling edges
// - event mode disables pin wake-up
// - toggle output inverts at each overflow outside PWM
// - flag and interrupt still work with buzzer
// - clearing toggle returns pin to GPIO when PWM is off
// - overflow is full scale to zero
// - PWM mode always reloads when enabled
// - PWM high at start, low at match
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module tcteb_timer
	import tcteb_pkg::*;
(
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       sys_rst,
	// register port
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output var  logic [7:0] reg_rdata,
	// event input and its port-side interrupt
	input  wire logic       event_input_pin,
	input  wire logic       ext_pin_irq_raw,
	output var  logic       ext_pin_interrupt_flag,
	output var  logic       ext_pin_wakeup_en,
	// shared output pin and its GPIO setting
	input  wire logic       gpio_out,
	input  wire logic       gpio_oe,
	output var  logic       shared_output_pin,
	output var  logic       shared_output_oe,
	// interrupt request to the controller
	output var  logic       timer_irq
);

	typedef struct packed {
		logic [7:0] mode;
		logic [7:0] count;
		logic [7:0] hold;
		logic [7:0] active;
		logic       flag;
		logic       ien;
		logic       ev_prev;
		logic       buzz;
		logic       pwm_lvl;
		logic       pin;
		logic       oe;
		logic       irq;
		logic       ext_flag;
		logic       wake_en;
		logic [7:0] rdata;
	} tcteb_state_t;

	tcteb_state_t state;
	tcteb_state_t next_state;

	logic       en;
	logic       pwm_on;
	logic       tog_on;
	logic       rel_on;
	logic       ext_clk;
	logic [2:0] rate;
	logic       pre_tick;
	logic       fall;
	logic       tick;
	logic [7:0] mask;
	logic       ovf;
	logic       wr_count;
	logic       wr_mode;
	logic       wr_reload;
	logic       wr_status;

	assign en      = state.mode[TCTEB_BIT_ENABLE];
	assign pwm_on  = state.mode[TCTEB_BIT_PWM_EN];
	assign tog_on  = state.mode[TCTEB_BIT_TOGGLE];
	assign rel_on  = state.mode[TCTEB_BIT_RELOAD];
	assign ext_clk = state.mode[TCTEB_BIT_CLK_SRC];
	assign rate    = state.mode[TCTEB_BIT_RATE_HI:TCTEB_BIT_RATE_LO];

	assign wr_count  = reg_wr && (reg_addr == TCTEB_OFS_COUNT);
	assign wr_mode   = reg_wr && (reg_addr == TCTEB_OFS_MODE);
	assign wr_reload = reg_wr && (reg_addr == TCTEB_OFS_RELOAD);
	assign wr_status = reg_wr && (reg_addr == TCTEB_OFS_STATUS);

	// internal clock path, held idle while the pin clocks the counter
	tcteb_prescaler u_pre (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.run     (en && !ext_clk),
		.rate    (rate),
		.tick    (pre_tick)
	);

	// falling edge of the event input
	assign fall = state.ev_prev && !event_input_pin;
	assign tick = en && (ext_clk ? fall : pre_tick);

	// overflow boundary
	always_comb begin
		mask = TCTEB_MASK_256;
		if (pwm_on && !ext_clk) begin
			case ({rel_on, tog_on})
				2'b00:   mask = TCTEB_MASK_256;
				2'b01:   mask = TCTEB_MASK_64;
				2'b10:   mask = TCTEB_MASK_32;
				2'b11:   mask = TCTEB_MASK_16;
				default: mask = TCTEB_MASK_256;
			endcase
		end
	end

	// full scale of the significant bits stepping to zero
	assign ovf = tick && ((state.count & mask) == mask);

	always_comb begin
		next_state = state;
		next_state.ev_prev = event_input_pin;

		// counter: step, wrap or reload; a software write wins
		if (ovf) begin
			next_state.active = state.hold;
			if (pwm_on) begin
				next_state.count = 8'h00;
			end else if (rel_on) begin
				next_state.count = state.hold;
			end else begin
				next_state.count = 8'h00;
			end
		end else if (tick) begin
			next_state.count = (state.count + 8'h01) & mask;
		end
		if (wr_count) begin
			next_state.count = reg_wdata;
		end
		if (wr_reload) begin
			next_state.hold = reg_wdata;
		end
		if (wr_mode) begin
			next_state.mode = reg_wdata;
		end

		// sticky overflow flag, set wins over a clearing write
		if (wr_status) begin
			next_state.ien  = reg_wdata[TCTEB_BIT_IEN];
			next_state.flag = state.flag && reg_wdata[TCTEB_BIT_FLAG];
		end
		if (ovf) begin
			next_state.flag = 1'b1;
		end
		next_state.irq = next_state.flag && next_state.ien;

		// buzzer toggles on each overflow with toggle on and PWM off
		if (ovf && tog_on && !pwm_on) begin
			next_state.buzz = !state.buzz;
		end

		// PWM: high from overflow, low once the count meets the duty
		if (!en || !pwm_on) begin
			next_state.pwm_lvl = 1'b1;
		end else if (ovf) begin
			next_state.pwm_lvl = 1'b1;
		end else if ((next_state.count & mask) == (state.active & mask)) begin
			next_state.pwm_lvl = 1'b0;
		end

		// shared pin selection, GPIO setting comes back when both off
		if (pwm_on) begin
			next_state.pin = state.pwm_lvl;
			next_state.oe  = 1'b1;
		end else if (tog_on) begin
			next_state.pin = state.buzz;
			next_state.oe  = 1'b1;
		end else begin
			next_state.pin = gpio_out;
			next_state.oe  = gpio_oe;
		end

		// event mode silences the pin's own interrupt and wake-up
		next_state.ext_flag = ext_pin_irq_raw && !ext_clk;
		next_state.wake_en  = !ext_clk;

		// read data, one cycle after the strobe
		next_state.rdata = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				TCTEB_OFS_MODE:   next_state.rdata = state.mode;
				TCTEB_OFS_COUNT:  next_state.rdata = state.count;
				TCTEB_OFS_STATUS: next_state.rdata = {6'h00, state.ien,
				                                      state.flag};
				default:          next_state.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			state         <= '0;
			state.mode    <= TCTEB_RST_MODE;
			state.count   <= TCTEB_RST_COUNT;
			state.hold    <= TCTEB_RST_RELOAD;
			state.active  <= TCTEB_RST_RELOAD;
			state.pwm_lvl <= 1'b1;
			state.wake_en <= 1'b1;
		end else begin
			state <= next_state;
		end
	end

	assign reg_rdata              = state.rdata;
	assign ext_pin_interrupt_flag = state.ext_flag;
	assign ext_pin_wakeup_en      = state.wake_en;
	assign shared_output_pin      = state.pin;
	assign shared_output_oe       = state.oe;
	assign timer_irq              = state.irq;

	// checks
	AST_FLAG_SET: assert property (@(posedge mclk) disable iff (sys_rst)
		ovf |=> state.flag)
		else $error("overflow did not set the flag");

	AST_FLAG_STICKY: assert property (@(posedge mclk) disable iff (sys_rst)
		state.flag && !wr_status |=> state.flag)
		else $error("flag dropped without a clearing write");

	AST_IRQ: assert property (
		@(posedge mclk) disable iff (sys_rst)
		ovf && state.ien && !wr_status |=> timer_irq)
		else $error("enabled overflow gave no interrupt");

	AST_EXT_BLOCK: assert property (@(posedge mclk) disable iff (sys_rst)
		ext_clk && !wr_mode |=> !ext_pin_interrupt_flag)
		else $error("pin interrupt raised in event mode");

	AST_WAKE_OFF: assert property (@(posedge mclk) disable iff (sys_rst)
		ext_clk && !wr_mode |=> !ext_pin_wakeup_en)
		else $error("wake-up left on in event mode");

	AST_RELOAD: assert property (@(posedge mclk) disable iff (sys_rst)
		ovf && rel_on && !pwm_on && !wr_count |=> state.count == $past(state.hold))
		else $error("counter not reloaded at overflow");

	AST_ACTIVE_HOLD: assert property (@(posedge mclk) disable iff (sys_rst)
		!ovf |=> $stable(state.active))
		else $error("active reload changed without overflow");

	AST_STOPPED: assert property (@(posedge mclk) disable iff (sys_rst)
		!en && !wr_count |=> $stable(state.count))
		else $error("stopped counter moved");

	AST_EVENT_STEP: assert property (@(posedge mclk) disable iff (sys_rst)
		en && ext_clk && fall && !ovf && !wr_count && !pwm_on
		|=> state.count == $past(state.count) + 8'h01)
		else $error("falling edge not counted");

	AST_TOGGLE: assert property (@(posedge mclk) disable iff (sys_rst)
		ovf && tog_on && !pwm_on |=> state.buzz != $past(state.buzz))
		else $error("buzzer did not toggle");

	AST_PWM_PIN: assert property (@(posedge mclk) disable iff (sys_rst)
		pwm_on && !wr_mode |=> shared_output_oe)
		else $error("pwm mode does not drive the pin");

	AST_GPIO_BACK: assert property (@(posedge mclk) disable iff (sys_rst)
		!pwm_on && !tog_on |=> shared_output_pin == $past(gpio_out))
		else $error("pin not returned to GPIO");

	AST_PWM_RISE: assert property (
		@(posedge mclk) disable iff (sys_rst)
		ovf && pwm_on && en |=> state.pwm_lvl)
		else $error("pwm level not high after overflow");

	AST_PWM_FALL: assert property (
		@(posedge mclk) disable iff (sys_rst)
		en && pwm_on && !ovf && !wr_mode && !wr_count
		##1 (state.count & mask) == (state.active & mask) |-> !state.pwm_lvl)
		else $error("pwm level not low at duty match");

	AST_PWM_RESTART: assert property (
		@(posedge mclk) disable iff (sys_rst)
		ovf && pwm_on && !wr_count |=> state.count == 8'h00)
		else $error("pwm cycle did not restart from zero");

	AST_WRAP: assert property (
		@(posedge mclk) disable iff (sys_rst)
		ovf && !pwm_on && !rel_on && !wr_count |=> state.count == 8'h00)
		else $error("counter did not wrap to zero");

	AST_ACTIVE_LOAD: assert property (
		@(posedge mclk) disable iff (sys_rst)
		ovf |=> state.active == $past(state.hold))
		else $error("holding buffer not moved at overflow");

	AST_LOW_BITS: assert property (
		@(posedge mclk) disable iff (sys_rst)
		tick && !ovf && !wr_count |=> (state.count & ~$past(mask)) == 8'h00)
		else $error("count left the significant bits");

	AST_PRE_IDLE: assert property (
		@(posedge mclk) disable iff (sys_rst)
		ext_clk |=> !pre_tick)
		else $error("prescaler ran while the pin clocks the counter");

	AST_BUZZ_HOLD: assert property (
		@(posedge mclk) disable iff (sys_rst)
		!ovf |=> $stable(state.buzz))
		else $error("buzzer changed without overflow");

	AST_BUZZ_PIN: assert property (
		@(posedge mclk) disable iff (sys_rst)
		tog_on && !pwm_on |=> shared_output_oe
			&& shared_output_pin == $past(state.buzz))
		else $error("buzzer not routed to the pin");

	AST_RD_IDLE: assert property (
		@(posedge mclk) disable iff (sys_rst)
		!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data outside the read answer cycle");

	AST_RELOAD_WO: assert property (
		@(posedge mclk) disable iff (sys_rst)
		reg_rd && reg_addr == TCTEB_OFS_RELOAD |=> reg_rdata == 8'h00)
		else $error("write-only reload register read back");

	CVR_OVF_RELOAD: cover property (@(posedge mclk) disable iff (sys_rst)
		ovf && rel_on && !pwm_on);
	CVR_EVENT_OVF: cover property (@(posedge mclk) disable iff (sys_rst)
		ovf && ext_clk);
	CVR_PWM16: cover property (@(posedge mclk) disable iff (sys_rst)
		ovf && pwm_on && rel_on && tog_on);
	CVR_FLAG_RACE: cover property (@(posedge mclk) disable iff (sys_rst)
		ovf && wr_status);

endmodule
`default_nettype wire

// *** dv/tcteb_partner.sv ***
// Purpose: event pulse source standing at the counter input pin
// Assumes: each pulse is two cycles low then two high, pin idles high
// Notes:   go is taken only while idle
`timescale 1ns/1ps
`default_nettype none
module tcteb_partner
	import tcteb_pkg::*;
(
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       sys_rst,
	// pulse request
	input  wire logic       go,
	input  wire logic [7:0] n_pulses,
	// pin side
	output var  logic       event_input_pin,
	output var  logic       busy
);
	logic [9:0] phase;

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			phase <= 10'h000;
		else if (go && phase == 10'h000)
			phase <= {n_pulses, 2'b00};
		else if (phase != 10'h000)
			phase <= phase - 10'h001;
	end

	// one falling edge per requested pulse
	assign event_input_pin = ~phase[1];
	assign busy            = phase != 10'h000;
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
// Purpose: self-checking bench of the timer/event counter
// Assumes: partner model makes the event pulses
// Notes:   expectations follow mode, count and reload settings
`timescale 1ns/1ps
`default_nettype none
module testbench
	import tcteb_pkg::*;
;
	logic       mclk = 1'b0;
	logic       sys_rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic       gpio_out = 1'b0;
	logic       gpio_oe = 1'b1;
	logic       pin_irq = 1'b1;
	logic       go = 1'b0;
	logic [7:0] n_pulses = 8'h00;
	logic [7:0] reg_rdata, v, c1;
	logic       ev_pin, ext_flag, wake_en, pin, pin_oe, irq, busy;
	int         n_fail = 0;
	int         n_compared = 0;
	int         hi;
	int         hi2;

	always #50 mclk = ~mclk;

	tcteb_timer tcteb_timer_i (.mclk(mclk), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .event_input_pin(ev_pin),
		.ext_pin_irq_raw(pin_irq), .ext_pin_interrupt_flag(ext_flag),
		.ext_pin_wakeup_en(wake_en), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
		.shared_output_pin(pin), .shared_output_oe(pin_oe),
		.timer_irq(irq));

	tcteb_partner tcteb_partner_i (.mclk(mclk), .sys_rst(sys_rst),
		.go(go), .n_pulses(n_pulses), .event_input_pin(ev_pin),
		.busy(busy));

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		d = reg_rdata;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd(a, d);
		chk(d, exp);
	endtask

	task automatic pulses(input logic [7:0] k);
		@(posedge mclk);
		go       <= 1'b1;
		n_pulses <= k;
		@(posedge mclk);
		go <= 1'b0;
		@(posedge mclk);
		while (busy) @(posedge mclk);
		repeat (3) @(negedge mclk);
	endtask

	task automatic high_cnt(output int h);
		h = 0;
		repeat (64) begin
			@(negedge mclk);
			h += pin;
		end
	endtask

	task automatic summarize;
		$display("compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge mclk);
		n_fail++;
		summarize;
	end

	initial begin
		repeat (10) @(posedge mclk);
		sys_rst <= 1'b0;
		rchk(TCTEB_OFS_MODE, TCTEB_RST_MODE);
		rchk(TCTEB_OFS_COUNT, TCTEB_RST_COUNT);
		rchk(TCTEB_OFS_RELOAD, 8'h00);
		rchk(8'h10, 8'h00);
		chk({6'h0, ext_flag, wake_en}, 8'h03);
		wr(TCTEB_OFS_COUNT, 8'h5a);
		wr(TCTEB_OFS_MODE, 8'h70);
		repeat (20) @(posedge mclk);
		rchk(TCTEB_OFS_COUNT, 8'h5a);
		rchk(TCTEB_OFS_MODE, 8'h70);
		// reads spaced four prescaler periods apart see four steps
		for (int r = 0; r < 8; r++) begin
			wr(TCTEB_OFS_MODE, 8'(r << 4));
			wr(TCTEB_OFS_MODE, 8'h80 | 8'(r << 4));
			repeat (600) @(posedge mclk);
			rd(TCTEB_OFS_COUNT, c1);
			repeat ((1024 >> r) - 2) @(posedge mclk);
			rd(TCTEB_OFS_COUNT, v);
			chk(v - c1, 8'h04);
		end
		// event counting with reload and buzzer, rate bits ignored
		wr(TCTEB_OFS_MODE, 8'h00);
		wr(TCTEB_OFS_STATUS, 8'h02);
		wr(TCTEB_OFS_COUNT, 8'hfe);
		wr(TCTEB_OFS_RELOAD, 8'hfe);
		wr(TCTEB_OFS_MODE, 8'h7e);
		wr(TCTEB_OFS_MODE, 8'hfe);
		wr(TCTEB_OFS_RELOAD, 8'h30);
		pulses(8'h01);
		rchk(TCTEB_OFS_COUNT, 8'hff);
		chk({7'h0, irq}, 8'h00);
		chk({6'h0, ext_flag, wake_en}, 8'h00);
		pulses(8'h01);
		rchk(TCTEB_OFS_STATUS, 8'h03);
		chk({5'h0, pin_oe, irq, pin}, 8'h07);
		rchk(TCTEB_OFS_COUNT, 8'h30);
		wr(TCTEB_OFS_STATUS, 8'h02);
		rchk(TCTEB_OFS_STATUS, 8'h02);
		pulses(8'hd0);
		rchk(TCTEB_OFS_COUNT, 8'h30);
		chk({6'h0, irq, pin}, 8'h02);
		@(posedge mclk);
		gpio_out <= 1'b1;
		wr(TCTEB_OFS_MODE, 8'hfc);
		repeat (2) @(negedge mclk);
		chk({6'h0, pin, pin_oe}, 8'h03);
		pulses(8'h01);
		rchk(TCTEB_OFS_COUNT, 8'h31);
		// without reload the count wraps to zero
		wr(TCTEB_OFS_MODE, 8'hf8);
		pulses(8'hcf);
		rchk(TCTEB_OFS_COUNT, 8'h00);
		// PWM, 16-count boundary, duty 4 with upper bits set
		wr(TCTEB_OFS_MODE, 8'h00);
		wr(TCTEB_OFS_RELOAD, 8'hf4);
		wr(TCTEB_OFS_COUNT, 8'h00);
		wr(TCTEB_OFS_MODE, 8'hf7);
		repeat (80) @(negedge mclk);
		high_cnt(hi);
		chk(8'(hi), 8'h10);
		// 32-count boundary, duty 0x14 of 32 counts, two cycles a count
		wr(TCTEB_OFS_MODE, 8'h00);
		wr(TCTEB_OFS_COUNT, 8'h00);
		wr(TCTEB_OFS_MODE, 8'hf5);
		repeat (80) @(negedge mclk);
		high_cnt(hi);
		chk(8'(hi), 8'h28);
		// 64-count boundary, duty 0x34, one period is 128 cycles
		wr(TCTEB_OFS_MODE, 8'h00);
		wr(TCTEB_OFS_COUNT, 8'h00);
		wr(TCTEB_OFS_MODE, 8'hf3);
		repeat (160) @(negedge mclk);
		high_cnt(hi);
		high_cnt(hi2);
		chk(8'(hi + hi2), 8'h68);
		@(posedge mclk);
		gpio_out <= 1'b0;
		gpio_oe  <= 1'b0;
		pin_irq  <= 1'b0;
		wr(TCTEB_OFS_MODE, 8'h80);
		repeat (2) @(negedge mclk);
		high_cnt(hi);
		chk(8'(hi), 8'h00);
		chk({6'h0, ext_flag, pin_oe}, 8'h00);
		summarize;
	end
endmodule
`default_nettype wire
